// file: hdl/rfcr_pkg.sv
// Constants for the RF transceiver command responder.
// Assumes one system clock and a synchronous active-low reset in every user.
package rfcr_pkg;

  // ==========================================================
  // Command group and sub-command codes
  localparam logic [15:0] GROUP_RF = 16'h2000;
  localparam logic [7:0] SUB_SET_ATTEN = 8'h51;
  localparam logic [7:0] SUB_GET_ATTEN = 8'h52;
  localparam logic [7:0] SUB_SET_DETECT = 8'h53;
  localparam logic [7:0] SUB_GET_DETECT = 8'h54;
  localparam logic [7:0] SUB_SET_LOSS = 8'h55;
  localparam logic [7:0] SUB_GET_LOSS = 8'h56;
  localparam logic [7:0] SUB_SET_UPLINK = 8'h57;
  localparam logic [7:0] SUB_GET_UPLINK = 8'h58;
  localparam logic [7:0] SUB_RESERVED = 8'h59;
  localparam logic [7:0] SUB_SET_FREQ = 8'h60;
  localparam logic [7:0] SUB_GET_FREQ = 8'h61;

  // ==========================================================
  // Response class bytes and status bytes
  localparam logic [7:0] CLS_SYNC_OK = 8'h88;
  localparam logic [7:0] CLS_ASYNC_OK = 8'h48;
  localparam logic [7:0] CLS_UNSOL_OK = 8'h28;
  localparam logic [7:0] CLS_SYNC_ERR = 8'h82;
  localparam logic [7:0] CLS_ASYNC_ERR = 8'h42;
  localparam logic [7:0] CLS_UNSOL_ERR = 8'h22;
  localparam logic [7:0] CLS_SYNC_CTL = 8'h81;
  localparam logic [7:0] CLS_ASYNC_CTL = 8'h41;
  localparam logic [7:0] CLS_UNSOL_CTL = 8'h21;
  localparam logic [7:0] ST_COMPLETE = 8'h00;
  localparam logic [7:0] ST_IN_PROGRESS = 8'h01;
  localparam logic [7:0] ST_LEN_ERR = 8'h00;
  localparam logic [7:0] ST_SEQ_ERR = 8'h01;
  localparam logic [7:0] ST_GROUP_ERR = 8'h03;
  localparam logic [7:0] ST_TIMEOUT = 8'h04;
  localparam logic [7:0] ST_FAILED = 8'h06;
  localparam logic [7:0] ST_SYSTEM = 8'h07;
  localparam logic [7:0] ST_SUBCMD = 8'h08;
  localparam logic [7:0] ST_DATA_ACK_ERR = 8'h09;
  localparam logic [7:0] ST_CTRL_WORD = 8'h0A;
  localparam logic [7:0] ST_ACK = 8'h00;
  localparam logic [7:0] ST_NACK = 8'h01;

  // ==========================================================
  // Setting fields
  localparam logic [7:0] FIELD_ACK = 8'h00;
  localparam logic [7:0] FIELD_NACK = 8'h01;
  localparam logic [3:0] PROTO_A = 4'h2;
  localparam logic [3:0] PROTO_B = 4'h3;
  localparam logic [3:0] PROTO_C = 4'h4;
  localparam logic [3:0] PROTO_D = 4'h8;
  localparam logic [15:0] DETECT_MAX = 16'h0014;
  localparam logic [2:0] PARAM_ATTEN = 3'h0;
  localparam logic [2:0] PARAM_DETECT = 3'h1;
  localparam logic [2:0] PARAM_LOSS = 3'h2;
  localparam logic [2:0] PARAM_UPLINK = 3'h3;
  localparam logic [2:0] PARAM_FREQ = 3'h4;
  localparam int CFG_AW = 5;
  localparam int CFG_DW = 16;

  // ==========================================================
  // Response buffer
  localparam int RESP_BYTES = 6;
  localparam logic [2:0] LEN_CODE = 3'h2;
  localparam logic [2:0] LEN_CODE8 = 3'h3;
  localparam logic [2:0] LEN_CODE16 = 3'h4;
  localparam logic [2:0] LEN_CODE32 = 3'h6;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_SEND = 3'b100
  } rfcr_state_t;

endpackage

// file: hdl/rfcr_cfg_mem.sv
// Small settings memory: one write port, one read port with registered data.
// Assumes writer and reader share sys_clk; contents are cleared by nrst.
`timescale 1ns/1ps
module rfcr_cfg_mem #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  // ==========================================================
  // Storage
  logic [DW-1:0] mem_q [2**AW];

  for (genvar i = 0; i < 2**AW; i++) begin : g_word
    always_ff @(posedge sys_clk) begin
      if (!nrst) begin
        mem_q[i] <= '0;
      end else if (wr_en && (wr_addr == AW'(i))) begin
        mem_q[i] <= wr_data;
      end
    end
  end

  // ==========================================================
  // Registered read
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule

// file: hdl/rfcr_responder.sv
// Command decoder and response generator for the RF transceiver command group.
// Assumes a framer in front that presents one decoded command at a time with its
// length and sequence figures, and a byte sink behind that takes responses.
`timescale 1ns/1ps
module rfcr_responder #(
  parameter int RESP_W = 8 * rfcr_pkg::RESP_BYTES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Decoded command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_async,
  input wire logic [15:0] cmd_group,
  input wire logic [7:0] cmd_sub,
  input wire logic [3:0] cmd_proto,
  input wire logic [15:0] cmd_value,
  input wire logic [15:0] len_exp,
  input wire logic [15:0] len_rcv,
  input wire logic [7:0] seq_exp,
  input wire logic [7:0] seq_rcv,
  // Host data acknowledge
  input wire logic ack_valid,
  output logic ack_ready,
  input wire logic [15:0] ack_value,
  // Execution events
  input wire logic evt_busy,
  input wire logic evt_timeout,
  input wire logic evt_system,
  input wire logic evt_ctrl_bad,
  // Response byte stream
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic tx_async
);

  // ==========================================================
  // State and captured command
  rfcr_pkg::rfcr_state_t state_q, state_d;
  logic cap_async_q;
  logic [15:0] cap_group_q;
  logic [7:0] cap_sub_q;
  logic [3:0] cap_proto_q;
  logic [15:0] cap_value_q;
  logic [15:0] cap_lexp_q;
  logic [15:0] cap_lrcv_q;
  logic [7:0] cap_sexp_q;
  logic [7:0] cap_srcv_q;
  logic [7:0] last_sub_q;

  // ==========================================================
  // Pending asynchronous slot and event flags
  logic slot_q, slot_d;
  logic [7:0] slot_code_q, slot_code_d;
  logic [31:0] slot_pay_q, slot_pay_d;
  logic [2:0] slot_len_q, slot_len_d;
  logic slot_ok_q, slot_ok_d;
  logic busy_q, tmo_q, sys_q, cw_q;
  logic clr_slot, clr_busy, clr_tmo, clr_sys, clr_cw;

  // ==========================================================
  // Transmit buffer
  logic [RESP_W-1:0] buf_q;
  logic [2:0] cnt_q;
  logic async_q;
  logic load_go;
  logic load_async;
  logic [RESP_W-1:0] load_buf;
  logic [2:0] load_len;

  // ==========================================================
  // Settings memory address decode
  function automatic logic [1:0] proto_idx(input logic [3:0] p);
    case (p)
      rfcr_pkg::PROTO_A: proto_idx = 2'd0;
      rfcr_pkg::PROTO_B: proto_idx = 2'd1;
      rfcr_pkg::PROTO_C: proto_idx = 2'd2;
      default: proto_idx = 2'd3;
    endcase
  endfunction

  function automatic logic [2:0] param_of(input logic [7:0] s);
    case (s)
      rfcr_pkg::SUB_SET_ATTEN, rfcr_pkg::SUB_GET_ATTEN: param_of = rfcr_pkg::PARAM_ATTEN;
      rfcr_pkg::SUB_SET_DETECT, rfcr_pkg::SUB_GET_DETECT: param_of = rfcr_pkg::PARAM_DETECT;
      rfcr_pkg::SUB_SET_LOSS, rfcr_pkg::SUB_GET_LOSS: param_of = rfcr_pkg::PARAM_LOSS;
      rfcr_pkg::SUB_SET_UPLINK, rfcr_pkg::SUB_GET_UPLINK: param_of = rfcr_pkg::PARAM_UPLINK;
      default: param_of = rfcr_pkg::PARAM_FREQ;
    endcase
  endfunction

  // ==========================================================
  // Command checks on the captured command
  wire is_idle = (state_q == rfcr_pkg::ST_IDLE);
  wire is_read = (state_q == rfcr_pkg::ST_READ);
  wire is_send = (state_q == rfcr_pkg::ST_SEND);
  wire take_cmd = cmd_valid && cmd_ready;
  wire take_ack = ack_valid && ack_ready;
  wire chk_len = (cap_lexp_q != cap_lrcv_q);
  wire chk_seq = (cap_sexp_q != cap_srcv_q);
  wire chk_grp = (cap_group_q != rfcr_pkg::GROUP_RF);
  wire sub_set = (cap_sub_q == rfcr_pkg::SUB_SET_ATTEN) ||
                 (cap_sub_q == rfcr_pkg::SUB_SET_DETECT) ||
                 (cap_sub_q == rfcr_pkg::SUB_SET_LOSS) ||
                 (cap_sub_q == rfcr_pkg::SUB_SET_UPLINK) ||
                 (cap_sub_q == rfcr_pkg::SUB_SET_FREQ);
  wire sub_get = (cap_sub_q == rfcr_pkg::SUB_GET_ATTEN) ||
                 (cap_sub_q == rfcr_pkg::SUB_GET_DETECT) ||
                 (cap_sub_q == rfcr_pkg::SUB_GET_LOSS) ||
                 (cap_sub_q == rfcr_pkg::SUB_GET_UPLINK) ||
                 (cap_sub_q == rfcr_pkg::SUB_GET_FREQ);
  wire sub_known = sub_set || sub_get;
  wire proto_ok = (cap_proto_q == rfcr_pkg::PROTO_A) || (cap_proto_q == rfcr_pkg::PROTO_B) ||
                  (cap_proto_q == rfcr_pkg::PROTO_C) || (cap_proto_q == rfcr_pkg::PROTO_D);
  wire range_bad = (cap_sub_q == rfcr_pkg::SUB_SET_DETECT) &&
                   (cap_value_q > rfcr_pkg::DETECT_MAX);
  wire set_nack = !proto_ok || range_bad;
  wire ack_good = (ack_value == {rfcr_pkg::CLS_SYNC_CTL, rfcr_pkg::ST_ACK}) ||
                  (ack_value == {rfcr_pkg::CLS_SYNC_CTL, rfcr_pkg::ST_NACK});
  wire [7:0] proto_byte = {cap_proto_q, 4'h0};
  wire [7:0] echo_hi = 8'h00;

  // ==========================================================
  // Settings memory
  wire mem_wr = is_read && !chk_len && !chk_seq && !chk_grp && sub_set && !set_nack;
  wire [rfcr_pkg::CFG_AW-1:0] wr_addr = {proto_idx(cap_proto_q), param_of(cap_sub_q)};
  wire [rfcr_pkg::CFG_AW-1:0] rd_addr = {proto_idx(cmd_proto), param_of(cmd_sub)};
  logic [rfcr_pkg::CFG_DW-1:0] mem_rdata;

  rfcr_cfg_mem #(
    .AW(rfcr_pkg::CFG_AW),
    .DW(rfcr_pkg::CFG_DW)
  ) u_cfg_mem (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wr_en(mem_wr),
    .wr_addr(wr_addr),
    .wr_data(cap_value_q),
    .rd_addr(rd_addr),
    .rd_data(mem_rdata)
  );

  // ==========================================================
  // Handshakes
  assign cmd_ready = is_idle && !slot_q;
  assign ack_ready = is_idle && !cmd_valid;
  assign tx_valid = is_send;
  assign tx_data = buf_q[RESP_W-1 -: 8];
  assign tx_last = is_send && (cnt_q == 3'h1);
  assign tx_async = async_q;

  // ==========================================================
  // Reply builder after the settings read
  always_comb begin
    slot_d = slot_q;
    slot_code_d = slot_code_q;
    slot_pay_d = slot_pay_q;
    slot_len_d = slot_len_q;
    slot_ok_d = slot_ok_q;
    load_go = 1'b0;
    load_async = 1'b0;
    load_buf = '0;
    load_len = rfcr_pkg::LEN_CODE;
    clr_slot = 1'b0;
    clr_busy = 1'b0;
    clr_tmo = 1'b0;
    clr_sys = 1'b0;
    clr_cw = 1'b0;
    if (is_read) begin
      slot_ok_d = 1'b0;
      if (chk_len) begin
        if (cap_async_q) begin
          slot_d = 1'b1;
          slot_code_d = rfcr_pkg::ST_LEN_ERR;
          slot_pay_d = {cap_lexp_q, cap_lrcv_q};
          slot_len_d = rfcr_pkg::LEN_CODE32;
        end else begin
          load_go = 1'b1;
          load_buf = {rfcr_pkg::CLS_SYNC_ERR, rfcr_pkg::ST_LEN_ERR, cap_lexp_q, cap_lrcv_q};
          load_len = rfcr_pkg::LEN_CODE32;
        end
      end else if (chk_seq) begin
        if (cap_async_q) begin
          slot_d = 1'b1;
          slot_code_d = rfcr_pkg::ST_SEQ_ERR;
          slot_pay_d = {cap_sexp_q, cap_srcv_q, 16'h0000};
          slot_len_d = rfcr_pkg::LEN_CODE16;
        end else begin
          load_go = 1'b1;
          load_buf = {rfcr_pkg::CLS_SYNC_ERR, rfcr_pkg::ST_SEQ_ERR, cap_sexp_q, cap_srcv_q,
                      16'h0000};
          load_len = rfcr_pkg::LEN_CODE16;
        end
      end else if (chk_grp) begin
        if (cap_async_q) begin
          slot_d = 1'b1;
          slot_code_d = rfcr_pkg::ST_GROUP_ERR;
          slot_pay_d = {cap_group_q, 16'h0000};
          slot_len_d = rfcr_pkg::LEN_CODE16;
        end else begin
          load_go = 1'b1;
          load_buf = {rfcr_pkg::CLS_SYNC_ERR, rfcr_pkg::ST_GROUP_ERR, cap_group_q,
                      16'h0000};
          load_len = rfcr_pkg::LEN_CODE16;
        end
      end else if (!sub_known) begin
        load_go = 1'b1;
        load_buf = {rfcr_pkg::CLS_SYNC_CTL, rfcr_pkg::ST_NACK, 32'h0000_0000};
        slot_d = 1'b1;
        slot_code_d = rfcr_pkg::ST_SUBCMD;
        slot_pay_d = {cap_sub_q, 24'h00_0000};
        slot_len_d = rfcr_pkg::LEN_CODE8;
      end else if (sub_set) begin
        load_go = 1'b1;
        load_buf = {cap_sub_q, proto_byte, set_nack ? rfcr_pkg::FIELD_NACK :
                    rfcr_pkg::FIELD_ACK, 24'h00_0000};
        load_len = rfcr_pkg::LEN_CODE8;
        slot_d = 1'b1;
        slot_code_d = set_nack ? rfcr_pkg::ST_FAILED : rfcr_pkg::ST_COMPLETE;
        slot_ok_d = !set_nack;
        slot_pay_d = {echo_hi, cap_sub_q, 16'h0000};
        slot_len_d = rfcr_pkg::LEN_CODE16;
      end else begin
        load_go = 1'b1;
        load_buf = {cap_sub_q, proto_byte, proto_ok ? mem_rdata : 16'h0000, 16'h0000};
        load_len = rfcr_pkg::LEN_CODE16;
        if (!proto_ok) begin
          slot_d = 1'b1;
          slot_code_d = rfcr_pkg::ST_FAILED;
          slot_pay_d = {echo_hi, cap_sub_q, 16'h0000};
          slot_len_d = rfcr_pkg::LEN_CODE16;
        end
      end
    end else if (is_idle && (!cmd_valid || slot_q)) begin
      if (take_ack && !ack_good) begin
        load_go = 1'b1;
        load_buf = {rfcr_pkg::CLS_SYNC_ERR, rfcr_pkg::ST_DATA_ACK_ERR, ack_value,
                    16'h0000};
        load_len = rfcr_pkg::LEN_CODE16;
      end else if (!take_ack) begin
        load_async = 1'b1;
        if (slot_q) begin
          load_go = 1'b1;
          clr_slot = 1'b1;
          load_buf = {slot_ok_q ? rfcr_pkg::CLS_ASYNC_OK :
                      rfcr_pkg::CLS_ASYNC_ERR, slot_code_q, slot_pay_q};
          load_len = slot_len_q;
        end else if (busy_q) begin
          load_go = 1'b1;
          clr_busy = 1'b1;
          load_buf = {rfcr_pkg::CLS_ASYNC_OK, rfcr_pkg::ST_IN_PROGRESS, echo_hi, last_sub_q,
                      16'h0000};
          load_len = rfcr_pkg::LEN_CODE16;
        end else if (tmo_q) begin
          load_go = 1'b1;
          clr_tmo = 1'b1;
          load_buf = {rfcr_pkg::CLS_ASYNC_ERR, rfcr_pkg::ST_TIMEOUT, 32'h0000_0000};
        end else if (sys_q) begin
          load_go = 1'b1;
          clr_sys = 1'b1;
          load_buf = {rfcr_pkg::CLS_ASYNC_ERR, rfcr_pkg::ST_SYSTEM, 32'h0000_0000};
        end else if (cw_q) begin
          load_go = 1'b1;
          clr_cw = 1'b1;
          load_buf = {rfcr_pkg::CLS_ASYNC_ERR, rfcr_pkg::ST_CTRL_WORD, 32'h0000_0000};
        end
      end
    end
    if (clr_slot) begin
      slot_d = 1'b0;
    end
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      rfcr_pkg::ST_IDLE: begin
        if (take_cmd) begin
          state_d = rfcr_pkg::ST_READ;
        end else if (load_go) begin
          state_d = rfcr_pkg::ST_SEND;
        end
      end
      rfcr_pkg::ST_READ: begin
        state_d = load_go ? rfcr_pkg::ST_SEND : rfcr_pkg::ST_IDLE;
      end
      rfcr_pkg::ST_SEND: begin
        if (tx_ready && tx_last) begin
          state_d = rfcr_pkg::ST_IDLE;
        end
      end
      default: state_d = rfcr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= rfcr_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Command capture
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cap_async_q <= 1'b0;
      cap_group_q <= 16'h0000;
      cap_sub_q <= 8'h00;
      cap_proto_q <= 4'h0;
      cap_value_q <= 16'h0000;
      cap_lexp_q <= 16'h0000;
      cap_lrcv_q <= 16'h0000;
      cap_sexp_q <= 8'h00;
      cap_srcv_q <= 8'h00;
    end else if (take_cmd) begin
      cap_async_q <= cmd_async;
      cap_group_q <= cmd_group;
      cap_sub_q <= cmd_sub;
      cap_proto_q <= cmd_proto;
      cap_value_q <= cmd_value;
      cap_lexp_q <= len_exp;
      cap_lrcv_q <= len_rcv;
      cap_sexp_q <= seq_exp;
      cap_srcv_q <= seq_rcv;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      last_sub_q <= 8'h00;
    end else if (mem_wr) begin
      last_sub_q <= cap_sub_q;
    end
  end

  // ==========================================================
  // Async slot and sticky event flags; a new event beats its clear
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      slot_q <= 1'b0;
      slot_code_q <= 8'h00;
      slot_pay_q <= 32'h0000_0000;
      slot_len_q <= rfcr_pkg::LEN_CODE;
      slot_ok_q <= 1'b0;
      busy_q <= 1'b0;
      tmo_q <= 1'b0;
      sys_q <= 1'b0;
      cw_q <= 1'b0;
    end else begin
      slot_q <= slot_d;
      slot_code_q <= slot_code_d;
      slot_pay_q <= slot_pay_d;
      slot_len_q <= slot_len_d;
      slot_ok_q <= slot_ok_d;
      busy_q <= (busy_q && !clr_busy) || evt_busy;
      tmo_q <= (tmo_q && !clr_tmo) || evt_timeout;
      sys_q <= (sys_q && !clr_sys) || evt_system;
      cw_q <= (cw_q && !clr_cw) || evt_ctrl_bad;
    end
  end

  // ==========================================================
  // Byte shifter, most significant byte first
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      buf_q <= '0;
      cnt_q <= 3'h0;
      async_q <= 1'b0;
    end else if (load_go && !take_cmd) begin
      buf_q <= load_buf;
      cnt_q <= load_len;
      async_q <= load_async;
    end else if (is_send && tx_ready) begin
      buf_q <= {buf_q[RESP_W-9:0], 8'h00};
      cnt_q <= cnt_q - 3'h1;
    end
  end

endmodule

// file: verification/rfcr_responder_props.sv
// Checker for the RF transceiver command responder.
// Assumes it is bound to rfcr_responder and sees only its ports.
`timescale 1ns/1ps
module rfcr_responder_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Command side
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_async,
  input wire logic [15:0] len_exp,
  input wire logic [15:0] len_rcv,
  // Host acknowledge
  input wire logic ack_valid,
  input wire logic ack_ready,
  input wire logic [15:0] ack_value,
  // Response stream
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_async
);
  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire take = cmd_valid && cmd_ready;
  wire ack_ctl = ack_value == 16'h8100 || ack_value == 16'h8101;
  chk_rst_ready: assert property ($rose(nrst) |-> cmd_ready && !tx_valid)
    else $error("not idle after reset");
  chk_take_read: assert property (take |=> !cmd_ready && !tx_valid)
    else $error("no read cycle after command");
  chk_len_sync: assert property (take && !cmd_async && len_exp != len_rcv
    |-> ##2 tx_valid && tx_data == 8'h82 && !tx_async)
    else $error("sync length error missing");
  chk_len_async: assert property (take && cmd_async && len_exp != len_rcv
    |-> ##2 !tx_valid ##[1:8] tx_valid && tx_async && tx_data == 8'h42)
    else $error("async length error missing");
  chk_tx_hold: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_data) && $stable(tx_last) && $stable(tx_async))
    else $error("byte changed while stalled");
  chk_resp_gap: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("no gap between responses");
  chk_ack_err: assert property (ack_valid && ack_ready && !ack_ctl
    |=> tx_valid && tx_data == 8'h82 && !tx_async)
    else $error("bad acknowledge not reported");
  chk_ack_ctl: assert property (ack_valid && ack_ready && ack_ctl |=> !tx_valid || tx_async)
    else $error("control acknowledge answered");
  chk_async_cls: assert property ($rose(tx_valid) && tx_async
    |-> tx_data == 8'h48 || tx_data == 8'h42)
    else $error("wrong async class byte");
  cover property (take && cmd_async);
  cover property (tx_valid && !tx_ready);
  cover property (tx_valid && tx_ready && tx_last && tx_async);
endmodule

bind rfcr_responder rfcr_responder_props u_props (.sys_clk, .nrst, .cmd_valid, .cmd_ready,
  .cmd_async, .len_exp, .len_rcv, .ack_valid, .ack_ready, .ack_value, .tx_valid, .tx_ready,
  .tx_data, .tx_last, .tx_async);

// file: verification/rfcr_host_sink.sv
// Host side model: takes response bytes, stalling by a pattern.
// Assumes the bench sets the pattern and reads got_q.
`timescale 1ns/1ps
module rfcr_host_sink (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Response stream
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_async,
  // Stall pattern, one bit a cycle
  input wire logic [7:0] stall
);
  logic [9:0] got_q[$];
  logic [2:0] cnt = 3'h0;
  initial tx_ready = 1'b0;
  // ==========================================================
  // Ready moves at the falling edge; bytes kept with their flags.
  always @(negedge sys_clk) begin
    tx_ready <= nrst && !stall[cnt];
    cnt <= cnt + 3'h1;
  end
  always @(posedge sys_clk) begin
    if (nrst && tx_valid && tx_ready) got_q.push_back({tx_async, tx_last, tx_data});
  end
endmodule

// file: verification/tb.sv
// Self-checking bench for the RF transceiver command responder.
// Assumes the responder, host sink and checker are compiled first.
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // Signals
  logic sys_clk = '0, nrst = '0, cmd_valid = '0, cmd_async = '0, ack_valid = '0;
  logic cmd_ready, ack_ready, tx_valid, tx_ready, tx_last, tx_async;
  logic evt_busy = '0, evt_timeout = '0, evt_system = '0, evt_ctrl_bad = '0;
  logic [15:0] cmd_group = '0, cmd_value = '0, len_exp = '0, len_rcv = '0, ack_value = '0;
  logic [7:0] cmd_sub = '0, seq_exp = '0, seq_rcv = '0, stall = '0, tx_data, last_set = '0;
  logic [3:0] cmd_proto = '0;
  logic [9:0] exp_q[$];
  logic [15:0] cfg[int];
  int miscompares = 0, total_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  rfcr_responder u_dut (.sys_clk, .nrst, .cmd_valid, .cmd_ready, .cmd_async, .cmd_group,
    .cmd_sub, .cmd_proto, .cmd_value, .len_exp, .len_rcv, .seq_exp, .seq_rcv, .ack_valid,
    .ack_ready, .ack_value, .evt_busy, .evt_timeout, .evt_system, .evt_ctrl_bad, .tx_valid,
    .tx_ready, .tx_data, .tx_last, .tx_async);
  rfcr_host_sink u_host (.sys_clk, .nrst, .tx_valid, .tx_ready, .tx_data, .tx_last,
    .tx_async, .stall);
  // ==========================================================
  // Model and compare
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic put(input logic a, input int n, input logic [47:0] v);
    for (int i = n - 1; i >= 0; i--) exp_q.push_back({a, i == 0, v[8*i +: 8]});
  endtask
  task automatic drain();
    int k;
    k = 0;
    while (u_host.got_q.size() < exp_q.size() && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    repeat (12) @(negedge sys_clk);
    check(10'(u_host.got_q.size()), 10'(exp_q.size()));
    foreach (exp_q[i]) check(u_host.got_q[i], exp_q[i]);
    exp_q.delete();
    u_host.got_q.delete();
  endtask
  task automatic run(input logic a, input logic [15:0] g, input logic [7:0] s,
    input logic [3:0] p, input logic [15:0] v);
    logic ok, nk;
    ok = p inside {4'h2, 4'h3, 4'h4, 4'h8};
    nk = !ok || (s == 8'h53 && v > 16'h0014);
    @(negedge sys_clk);
    {cmd_valid, cmd_async, cmd_group, cmd_sub, cmd_proto, cmd_value} = {1'b1, a, g, s, p, v};
    while (!cmd_ready) @(negedge sys_clk);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    if (len_exp != len_rcv) put(a, 6, {a ? 8'h42 : 8'h82, 8'h00, len_exp, len_rcv});
    else if (seq_exp != seq_rcv) put(a, 4, {a ? 8'h42 : 8'h82, 8'h01, seq_exp, seq_rcv});
    else if (g != 16'h2000) put(a, 4, {a ? 8'h42 : 8'h82, 8'h03, g});
    else if (!(s inside {[8'h51:8'h58], 8'h60, 8'h61})) begin
      put(0, 2, 16'h8101);
      put(1, 3, {16'h4208, s});
    end else if (s inside {8'h51, 8'h53, 8'h55, 8'h57, 8'h60}) begin
      put(0, 3, {s, p, 11'h000, nk});
      put(1, 4, {nk ? 16'h4206 : 16'h4800, 8'h00, s});
      if (!nk) cfg[{p, s + 8'h01}] = v;
      if (!nk) last_set = s;
    end else begin
      put(0, 4, {s, p, 4'h0, ok && cfg.exists({p, s}) ? cfg[{p, s}] : 16'h0000});
      if (!ok) put(1, 4, {16'h4206, 8'h00, s});
    end
    drain();
  endtask
  task automatic ack(input logic [15:0] v);
    @(negedge sys_clk);
    {ack_valid, ack_value} = {1'b1, v};
    while (!ack_ready) @(negedge sys_clk);
    @(negedge sys_clk);
    ack_valid = 1'b0;
    if (v != 16'h8100 && v != 16'h8101) put(0, 4, {16'h8209, v});
    drain();
  endtask
  task automatic pulse(input logic [3:0] w);
    @(negedge sys_clk);
    {evt_busy, evt_timeout, evt_system, evt_ctrl_bad} = w;
    @(negedge sys_clk);
    {evt_busy, evt_timeout, evt_system, evt_ctrl_bad} = 4'h0;
    if (w[3]) put(1, 4, {16'h4801, 8'h00, last_set});
    if (w[2]) put(1, 2, 16'h4204);
    if (w[1]) put(1, 2, 16'h4207);
    if (w[0]) put(1, 2, 16'h420a);
    drain();
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    final_report();
  end
  initial begin
    logic [3:0] pv[4];
    logic [7:0] s;
    logic [15:0] v;
    pv = '{4'h2, 4'h3, 4'h4, 4'h8};
    void'($urandom(32'hf4ea_11b3));
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    len_exp = 16'h0012;
    len_rcv = 16'h0013;
    for (int a = 0; a < 2; a++) run(a[0], 16'h2000, 8'h51, 4'h2, 16'h0003);
    len_rcv = len_exp;
    seq_rcv = 8'h06;
    for (int a = 0; a < 2; a++) run(a[0], 16'h2000, 8'h51, 4'h2, 16'h0003);
    seq_rcv = seq_exp;
    for (int a = 0; a < 2; a++) run(a[0], 16'h2100, 8'h52, 4'h3, 16'h0000);
    run(0, 16'h2000, 8'h59, 4'h2, 16'h0000);
    stall = 8'($urandom()) & 8'h7f;
    foreach (pv[i]) for (int k = 0; k < 5; k++) begin
      s = k == 4 ? 8'h60 : 8'h51 + 8'(2 * k);
      v = 16'($urandom());
      run(0, 16'h2000, s, pv[i], s == 8'h53 ? v % 16'h0015 : v);
      run(0, 16'h2000, s + 8'h01, pv[i], 16'h0000);
    end
    run(0, 16'h2000, 8'h53, 4'h8, 16'h0014);
    run(0, 16'h2000, 8'h53, 4'h8, 16'h0015);
    run(0, 16'h2000, 8'h54, 4'h8, 16'h0000);
    run(0, 16'h2000, 8'h55, 4'h5, 16'h0009);
    run(0, 16'h2000, 8'h56, 4'h5, 16'h0000);
    ack(16'h8100);
    ack(16'h8101);
    ack(16'($urandom()));
    for (int w = 8; w > 0; w = w / 2) pulse(4'(w));
    pulse(4'hf);
    final_report();
  end
endmodule
